// file: rtl/scw6_word6.sv
// serial receiver and field store for the sixth configuration word
`timescale 1ns/1ps
module scw6_word6
   import scw6_pkg::*;
#(
   parameter int FRACTION_W = 16
)
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_spi_clk,
   input wire logic i_spi_data,
   input wire logic i_spi_cs_n,
   input wire logic [1:0] i_output_a_level_code,
   input wire logic [1:0] i_output_b_level_code,
   input wire logic [scw6_pkg::LOW_COUNT_W-1:0] i_band_clock_counter_low,
   input wire logic [FRACTION_W-1:0] i_fraction,
   output scw6_pkg::scw6_dbm_t o_output_a_dbm,
   output scw6_pkg::scw6_dbm_t o_output_b_dbm,
   output logic o_output_a_power_boost,
   output logic o_output_b_power_boost,
   output logic [1:0] o_modulator_order,
   output logic o_modulator_on,
   output logic o_integer_mode,
   output logic [FRACTION_W-1:0] o_fraction_effective,
   output logic o_dither_gain_select,
   output logic [2:0] o_dither_step_lsbs,
   output logic o_dither_shaping_on,
   output logic o_modulator_structure,
   output logic [1:0] o_band_search_accuracy,
   output logic [2:0] o_band_compare_cycles,
   output logic o_band_accuracy_reserved,
   output logic [scw6_pkg::DIV_MSBS_W-1:0] o_band_clock_divider_msbs,
   output logic [scw6_pkg::DIVIDE_W-1:0] o_band_clock_divide,
   output logic [scw6_pkg::WORD_BITS-1:0] o_config_word,
   output logic o_word_loaded,
   output logic o_frame_error
);
   import scw6_pkg::*;

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [2:0] sclk_sync;
   logic [2:0] sdat_sync;
   logic [2:0] cs_sync;
   logic sclk_level;
   logic sdat_level;
   logic cs_n_level;
   logic sclk_rise;
   logic cs_fall;
   logic cs_rise;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         sclk_sync <= 3'h0;
         sdat_sync <= 3'h0;
         cs_sync <= 3'h7;
      end else begin
         sclk_sync <= {sclk_sync[1:0], i_spi_clk};
         sdat_sync <= {sdat_sync[1:0], i_spi_data};
         cs_sync <= {cs_sync[1:0], i_spi_cs_n};
      end
   end

   // a level only moves once stages two and three agree
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         sclk_level <= 1'b0;
         sdat_level <= 1'b0;
         cs_n_level <= 1'b1;
      end else begin
         if (sclk_sync[1] == sclk_sync[2]) begin
            sclk_level <= sclk_sync[2];
         end
         if (sdat_sync[1] == sdat_sync[2]) begin
            sdat_level <= sdat_sync[2];
         end
         if (cs_sync[1] == cs_sync[2]) begin
            cs_n_level <= cs_sync[2];
         end
      end
   end

   assign sclk_rise = (sclk_sync[1] == sclk_sync[2]) && sclk_sync[2] && !sclk_level;
   assign cs_fall = (cs_sync[1] == cs_sync[2]) && !cs_sync[2] && cs_n_level;
   assign cs_rise = (cs_sync[1] == cs_sync[2]) && cs_sync[2] && !cs_n_level;

   // ************************************************************
   // frame shifter
   // ************************************************************
   scw6_frame_t frame_state;
   logic [WORD_BITS-1:0] shift_word;
   logic [5:0] bit_count;
   logic frame_good;
   logic frame_match;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         frame_state <= FR_IDLE;
      end else begin
         case (frame_state)
            FR_IDLE: begin
               if (cs_fall) begin
                  frame_state <= FR_SHIFT;
               end
            end
            FR_SHIFT: begin
               if (cs_rise) begin
                  frame_state <= FR_IDLE;
               end
            end
            default: frame_state <= FR_IDLE;
         endcase
      end
   end

   // data settles with the same latency as the clock, so the raw third stage is safe here
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         shift_word <= '0;
         bit_count <= 6'h00;
      end else if (cs_fall) begin
         bit_count <= 6'h00;
      end else if (frame_state == FR_SHIFT && sclk_rise) begin
         shift_word <= {shift_word[WORD_BITS-2:0], sdat_sync[2]};
         if (bit_count != 6'h3F) begin
            bit_count <= bit_count + 6'h01;
         end
      end
   end

   assign frame_good = (bit_count == 6'(WORD_BITS));
   assign frame_match = shift_word[POS_SELECT_LSB +: 3] == WORD_SELECT_CODE;

   // ************************************************************
   // stored fields
   // ************************************************************
   logic load_word;
   logic boost_a;
   logic boost_b;
   logic [1:0] order;
   logic dither_gain;
   logic shaping;
   logic structure;
   logic [1:0] band_acc;
   logic [DIV_MSBS_W-1:0] div_msbs;

   // a short frame never loads, so a truncated word cannot corrupt the store
   assign load_word = frame_state == FR_SHIFT && cs_rise && frame_good && frame_match;

   // other control codes fall through and keep the stored values
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         boost_a <= RST_BOOST;
         boost_b <= RST_BOOST;
      end else if (load_word) begin
         boost_a <= shift_word[POS_BOOST_A];
         boost_b <= shift_word[POS_BOOST_B];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         order <= RST_ORDER;
         dither_gain <= RST_DITHER_GAIN;
         shaping <= RST_SHAPING;
         structure <= RST_STRUCTURE;
      end else if (load_word) begin
         order <= shift_word[POS_ORDER_LSB +: 2];
         dither_gain <= shift_word[POS_DITHER_GAIN];
         shaping <= shift_word[POS_SHAPING];
         structure <= shift_word[POS_STRUCTURE];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         band_acc <= RST_BAND_ACC;
         div_msbs <= RST_DIV_MSBS;
      end else if (load_word) begin
         band_acc <= shift_word[POS_BAND_ACC_LSB +: 2];
         div_msbs <= shift_word[POS_DIV_MSBS_LSB +: DIV_MSBS_W];
      end
   end

   // ************************************************************
   // derived controls
   // ************************************************************
   function automatic logic [2:0] pow2_cycles(input logic [1:0] code);
      logic [2:0] v;
      v = 3'h1;
      case (code)
         2'h0: v = 3'h1;
         2'h1: v = 3'h2;
         2'h2: v = 3'h4;
         default: v = 3'h1;
      endcase
      return v;
   endfunction

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_modulator_on <= 1'b1;
         o_integer_mode <= 1'b0;
         o_fraction_effective <= '0;
      end else begin
         o_modulator_on <= order != ORDER_OFF;
         o_integer_mode <= order == ORDER_OFF;
         o_fraction_effective <= (order == ORDER_OFF) ? '0 : i_fraction;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_dither_step_lsbs <= 3'h1;
         o_band_compare_cycles <= 3'h1;
         o_band_accuracy_reserved <= 1'b0;
      end else begin
         o_dither_step_lsbs <= dither_gain ? 3'h4 : 3'h1;
         // reserved accuracy code falls back to the one-cycle interval
         o_band_compare_cycles <= pow2_cycles(band_acc);
         o_band_accuracy_reserved <= band_acc == BAND_ACC_RESERVED;
      end
   end

   // the host keeps the resulting band clock under its limit; no check here
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_band_clock_divide <= '0;
      end else begin
         o_band_clock_divide <= {div_msbs, i_band_clock_counter_low};
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_word_loaded <= 1'b0;
         o_frame_error <= 1'b0;
      end else begin
         o_word_loaded <= load_word;
         o_frame_error <= frame_state == FR_SHIFT && cs_rise && !frame_good;
      end
   end

   // readback view; the two must-be-zero positions read as zero
   always_comb begin
      o_config_word = '0;
      o_config_word[POS_SELECT_LSB +: 3] = WORD_SELECT_CODE;
      o_config_word[POS_BAND_ACC_LSB +: 2] = band_acc;
      o_config_word[POS_STRUCTURE] = structure;
      o_config_word[POS_SHAPING] = shaping;
      o_config_word[POS_ZERO_LOW] = 1'b0;
      o_config_word[POS_DITHER_GAIN] = dither_gain;
      o_config_word[POS_ORDER_LSB +: 2] = order;
      o_config_word[POS_BOOST_A] = boost_a;
      o_config_word[POS_BOOST_B] = boost_b;
      o_config_word[POS_DIV_MSBS_LSB +: DIV_MSBS_W] = div_msbs;
      o_config_word[POS_ZERO_HIGH] = 1'b0;
   end

   assign o_output_a_power_boost = boost_a;
   assign o_output_b_power_boost = boost_b;
   assign o_modulator_order = order;
   assign o_dither_gain_select = dither_gain;
   assign o_dither_shaping_on = shaping;
   assign o_modulator_structure = structure;
   assign o_band_search_accuracy = band_acc;
   assign o_band_clock_divider_msbs = div_msbs;

   // ************************************************************
   // output level decode
   // ************************************************************
   scw6_power_map u_map_a (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_boost(boost_a),
      .i_level_code(i_output_a_level_code),
      .o_dbm(o_output_a_dbm)
   );

   scw6_power_map u_map_b (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_boost(boost_b),
      .i_level_code(i_output_b_level_code),
      .o_dbm(o_output_b_dbm)
   );
endmodule

// file: rtl/scw6_pkg.sv
// constants and types for the sixth synthesizer configuration word
package scw6_pkg;
   // ************************************************************
   // serial framing
   // ************************************************************
   localparam int WORD_BITS = 32;
   localparam logic [2:0] WORD_SELECT_CODE = 3'h6;
   // ************************************************************
   // field positions inside the word
   // ************************************************************
   localparam int POS_SELECT_LSB = 0;
   localparam int POS_BAND_ACC_LSB = 3;
   localparam int POS_STRUCTURE = 5;
   localparam int POS_SHAPING = 6;
   localparam int POS_ZERO_LOW = 7;
   localparam int POS_DITHER_GAIN = 8;
   localparam int POS_ORDER_LSB = 9;
   localparam int POS_BOOST_A = 11;
   localparam int POS_BOOST_B = 12;
   localparam int POS_DIV_MSBS_LSB = 13;
   localparam int POS_ZERO_HIGH = 19;
   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic RST_BOOST = 1'b0;
   localparam logic [1:0] RST_ORDER = 2'h3;
   localparam logic RST_DITHER_GAIN = 1'b0;
   localparam logic RST_SHAPING = 1'b1;
   localparam logic RST_STRUCTURE = 1'b1;
   localparam logic [1:0] RST_BAND_ACC = 2'h0;
   localparam logic [3:0] RST_DIV_MSBS = 4'h0;
   // ************************************************************
   // encodings and scale factors
   // ************************************************************
   localparam logic [1:0] ORDER_OFF = 2'h0;
   localparam logic [1:0] BAND_ACC_RESERVED = 2'h3;
   localparam logic STRUCTURE_VARIANT_B = 1'b0;
   localparam logic STRUCTURE_VARIANT_TWO = 1'b1;
   localparam int DIV_MSB_WEIGHT_LOG2 = 8;
   localparam int DIV_MSBS_W = 4;
   localparam int LOW_COUNT_W = 8;
   localparam int DIVIDE_W = 12;
   typedef logic signed [3:0] scw6_dbm_t;
   typedef enum logic [0:0] {FR_IDLE, FR_SHIFT} scw6_frame_t;
endpackage

// file: rtl/scw6_power_map.sv
// output level decoder: boost bit plus two-bit level code to dBm
`timescale 1ns/1ps
module scw6_power_map
   import scw6_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_boost,
   input wire logic [1:0] i_level_code,
   output scw6_pkg::scw6_dbm_t o_dbm
);
   import scw6_pkg::*;

   function automatic scw6_dbm_t level_to_dbm(input logic boost, input logic [1:0] code);
      scw6_dbm_t v;
      v = 4'sh0;
      case ({boost, code})
         3'h0: v = -4'sd4;
         3'h1: v = -4'sd1;
         3'h2: v = 4'sd2;
         3'h3: v = 4'sd5;
         3'h4: v = 4'sd2;
         3'h5: v = 4'sd5;
         3'h6: v = 4'sd6;
         default: v = 4'sd7;
      endcase
      return v;
   endfunction

   // registered so the level reads steady against code glitches
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_dbm <= -4'sd4;
      end else begin
         o_dbm <= level_to_dbm(i_boost, i_level_code);
      end
   end
endmodule

// file: dv/scw6_word6_asserts.sv
// concurrent checks on the sixth configuration word block
`timescale 1ns/1ps
module scw6_word6_asserts
   import scw6_pkg::*;
#(
   parameter int FRACTION_W = 16
)
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic [1:0] i_output_a_level_code,
   input wire logic [1:0] i_output_b_level_code,
   input wire logic [scw6_pkg::LOW_COUNT_W-1:0] i_band_clock_counter_low,
   input wire logic [FRACTION_W-1:0] i_fraction,
   input wire scw6_pkg::scw6_dbm_t o_output_a_dbm,
   input wire scw6_pkg::scw6_dbm_t o_output_b_dbm,
   input wire logic o_output_a_power_boost,
   input wire logic o_output_b_power_boost,
   input wire logic [1:0] o_modulator_order,
   input wire logic o_modulator_on,
   input wire logic o_integer_mode,
   input wire logic [FRACTION_W-1:0] o_fraction_effective,
   input wire logic o_dither_gain_select,
   input wire logic [2:0] o_dither_step_lsbs,
   input wire logic [1:0] o_band_search_accuracy,
   input wire logic [2:0] o_band_compare_cycles,
   input wire logic o_band_accuracy_reserved,
   input wire logic [scw6_pkg::DIV_MSBS_W-1:0] o_band_clock_divider_msbs,
   input wire logic [scw6_pkg::DIVIDE_W-1:0] o_band_clock_divide,
   input wire logic [scw6_pkg::WORD_BITS-1:0] o_config_word,
   input wire logic o_word_loaded,
   input wire logic o_frame_error
);
   import scw6_pkg::*;
   // ************
   // properties
   // ************
   localparam logic [3:0] DBM [8] = '{4'hC, 4'hF, 4'h2, 4'h5, 4'h2, 4'h5, 4'h6, 4'h7};
   localparam logic [2:0] CMP [4] = '{3'h1, 3'h2, 3'h4, 3'h1};
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   sequence s_store_change;
      $changed(o_config_word);
   endsequence
   sequence s_load_pulse;
      o_word_loaded ##1 !o_word_loaded;
   endsequence
   // registered outputs only track after the first clean edge
   dbm_a_map_a: assert property (!$past(i_reset) |-> o_output_a_dbm == DBM[{$past(o_output_a_power_boost), $past(i_output_a_level_code)}]) else $error("dbm a map");
   dbm_b_map_a: assert property (!$past(i_reset) |-> o_output_b_dbm == DBM[{$past(o_output_b_power_boost), $past(i_output_b_level_code)}]) else $error("dbm b map");
   integer_mode_a: assert property (!$past(i_reset) |-> o_integer_mode == ($past(o_modulator_order) == ORDER_OFF) && o_modulator_on != o_integer_mode) else $error("integer mode");
   fraction_gate_a: assert property (!$past(i_reset) |-> o_fraction_effective == (($past(o_modulator_order) == ORDER_OFF) ? '0 : $past(i_fraction))) else $error("fraction gate");
   dither_step_a: assert property (!$past(i_reset) |-> o_dither_step_lsbs == ($past(o_dither_gain_select) ? 3'h4 : 3'h1)) else $error("dither step");
   band_compare_a: assert property (!$past(i_reset) |-> o_band_compare_cycles == CMP[$past(o_band_search_accuracy)] && o_band_accuracy_reserved == ($past(o_band_search_accuracy) == BAND_ACC_RESERVED)) else $error("band compare");
   band_divide_a: assert property (!$past(i_reset) |-> o_band_clock_divide == {$past(o_band_clock_divider_msbs), $past(i_band_clock_counter_low)}) else $error("band divide");
   readback_fixed_a: assert property (o_config_word[2:0] == WORD_SELECT_CODE && !o_config_word[7] && !o_config_word[19] && o_config_word[10:9] == o_modulator_order && o_config_word[16:13] == o_band_clock_divider_msbs) else $error("readback");
   // the load pulse and the new store value show up at the same sampling edge
   store_only_load_a: assert property (s_store_change |-> s_load_pulse) else $error("store change");
   frame_error_a: assert property (o_frame_error |-> !o_word_loaded ##1 !o_frame_error) else $error("frame error");
endmodule
bind scw6_word6 scw6_word6_asserts #(.FRACTION_W(FRACTION_W)) u_chk (.*);

// file: dv/scw6_host.sv
// host model shifting configuration words into the serial pins
`timescale 1ns/1ps
module scw6_host
(
   input wire logic i_clk,
   output logic o_spi_clk,
   output logic o_spi_data,
   output logic o_spi_cs_n
);
   initial begin
      o_spi_clk = 1'b0;
      o_spi_data = 1'b0;
      o_spi_cs_n = 1'b1;
   end
   // five cycles per level, three more than the two the pin filter needs
   task automatic shift_word(input logic [31:0] word, input int n_bits);
      logic [31:0] w;
      w = word;
      w[7] = 1'b0;
      w[19] = 1'b0;
      @(posedge i_clk);
      o_spi_cs_n <= 1'b0;
      repeat (5) @(posedge i_clk);
      for (int b = 31; b > 31 - n_bits; b--) begin
         o_spi_data <= w[b];
         repeat (5) @(posedge i_clk);
         o_spi_clk <= 1'b1;
         repeat (5) @(posedge i_clk);
         o_spi_clk <= 1'b0;
      end
      repeat (5) @(posedge i_clk);
      o_spi_cs_n <= 1'b1;
      // released line must not keep the last bit
      o_spi_data <= ~o_spi_data;
      repeat (6) @(posedge i_clk);
   endtask
   task automatic send(input logic [31:0] word);
      shift_word(word, 32);
      if (word[2:0] == 3'h6) begin
         shift_word(32'h0, 32);
      end
   endtask
endmodule

// file: dv/tb_top.sv
// self-checking bench for the sixth configuration word block
`timescale 1ns/1ps
module tb_top;
   import scw6_pkg::*;
   localparam logic [3:0] DBM [8] = '{4'hC, 4'hF, 4'h2, 4'h5, 4'h2, 4'h5, 4'h6, 4'h7};
   localparam logic [2:0] CMP [4] = '{3'h1, 3'h2, 3'h4, 3'h1};
   logic i_clk = 1'b0;
   logic i_reset = 1'b1;
   logic [1:0] i_output_a_level_code = 2'h0, i_output_b_level_code = 2'h0;
   logic [7:0] i_band_clock_counter_low = 8'h00;
   logic [15:0] i_fraction = 16'hA5C3;
   wire logic i_spi_clk, i_spi_data, i_spi_cs_n;
   scw6_dbm_t o_output_a_dbm, o_output_b_dbm;
   logic o_output_a_power_boost, o_output_b_power_boost, o_modulator_on, o_integer_mode;
   logic [1:0] o_modulator_order, o_band_search_accuracy;
   logic [15:0] o_fraction_effective;
   logic [2:0] o_dither_step_lsbs, o_band_compare_cycles;
   logic o_dither_gain_select, o_dither_shaping_on, o_modulator_structure, o_band_accuracy_reserved;
   logic [3:0] o_band_clock_divider_msbs;
   logic [11:0] o_band_clock_divide;
   logic [31:0] o_config_word;
   logic o_word_loaded, o_frame_error;
   int n_mismatch = 0, n_compared = 0, n_loads = 0, n_errs = 0, cycles = 0;
   scw6_word6 u_dut (.*);
   scw6_host u_host (.i_clk(i_clk), .o_spi_clk(i_spi_clk), .o_spi_data(i_spi_data), .o_spi_cs_n(i_spi_cs_n));
   always #5 i_clk = ~i_clk;
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (o_word_loaded === 1'b1) n_loads <= n_loads + 1;
      if (o_frame_error === 1'b1) n_errs <= n_errs + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   // ************
   // compares
   // ************
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic check_count(input int got, input int exp, input string what);
      n_compared++;
      if (got != exp) begin
         n_mismatch++;
         $display("MISMATCH %0t %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask
   function automatic logic [31:0] mk(input int i, input logic [2:0] sel);
      return {15'h0, {2{i[1:0]}}, i[0], i[1], i[1:0], !i[0], 1'b0, i[0], !i[1], i[1:0], sel};
   endfunction
   // ************
   // scenarios
   // ************
   task automatic t_reset_values();
      check_val({o_output_b_power_boost, o_output_a_power_boost, o_modulator_order, o_dither_gain_select,
                 o_dither_shaping_on, o_modulator_structure, o_band_search_accuracy, o_band_clock_divider_msbs},
                13'b0_0_11_0_1_1_00_0000, "reset fields");
      check_val(o_config_word, 32'h0000_0666, "reset word");
   endtask
   task automatic t_write_fields();
      logic [31:0] w;
      for (int i = 0; i < 4; i++) begin
         w = mk(i, 3'h6);
         @(posedge i_clk);
         i_band_clock_counter_low <= {4{i[1:0]}};
         u_host.send(w);
         repeat (4) @(posedge i_clk);
         check_count(n_loads, i + 1, "loads");
         check_val(o_config_word, w, "word");
         check_val({o_output_b_power_boost, o_output_a_power_boost, o_modulator_order, o_dither_gain_select,
                    o_band_search_accuracy, o_band_clock_divider_msbs}, {w[12:8], w[4:3], w[16:13]},
                   "fields");
         check_val({o_modulator_on, o_integer_mode}, (i == 0) ? 2'b01 : 2'b10, "mode");
         check_val(o_fraction_effective, (i == 0) ? 16'h0 : 16'hA5C3, "fraction");
         check_val(o_dither_step_lsbs, w[8] ? 3'h4 : 3'h1, "dither");
         check_val({o_dither_shaping_on, o_modulator_structure}, w[6:5], "shape");
         check_val({o_band_compare_cycles, o_band_accuracy_reserved}, {CMP[i], i == 3}, "band");
         check_val(o_band_clock_divide, 32'(i_band_clock_counter_low) + 256 * w[16:13], "divide");
         for (int c = 0; c < 4; c++) begin
            i_output_a_level_code <= 2'(c);
            i_output_b_level_code <= 2'(3 - c);
            repeat (2) @(posedge i_clk);
            check_val({28'h0, o_output_a_dbm}, DBM[{w[11], 2'(c)}], "dbm a");
            check_val({28'h0, o_output_b_dbm}, DBM[{w[12], 2'(3 - c)}], "dbm b");
         end
      end
   endtask
   task automatic t_wrong_code();
      for (int s = 0; s < 8; s++) begin
         if (s != 6) begin
            u_host.send(mk(1, 3'(s)));
            repeat (4) @(posedge i_clk);
            check_val(o_config_word, mk(3, 3'h6), "kept");
         end
      end
      check_count(n_loads, 4, "no load");
      check_count(n_errs, 0, "no error");
   endtask
   task automatic t_short_frame();
      u_host.shift_word(mk(0, 3'h6), 31);
      repeat (4) @(posedge i_clk);
      check_count(n_errs, 1, "error");
      check_val(o_config_word, mk(3, 3'h6), "kept");
   endtask
   initial begin
      repeat (8) @(posedge i_clk);
      i_reset <= 1'b0;
      @(posedge i_clk);
      t_reset_values();
      t_write_fields();
      t_wrong_code();
      t_short_frame();
      check_count(n_loads, 4, "loads end");
      print_verdict();
   end
endmodule
